// ### design/dss_pkg.sv
// Function
// - override bit picks interface, else detected
// - interface choice: zero analog, one digital
// - choice acts under override or both present
// - hsync override or both present takes select bit, else detected
// - hsync select: pin or green, gated
// - vsync override takes select bit, else detected
// - vsync select: raw or separated, override only
// - coast source: coast pin or vsync
// - active-low chip sleep, default one
// - separator counts to threshold, default 0x20
// - coast polarity override uses pll register bit
// - hsync polarity override uses pll register bit
// - read-only polarity status, three bits
// - coast leads vsync by lead lines
// - coast trails vsync by trail lines
// - slicer threshold upper five bits, bits1:0 zeroed on write
// - format bit: one 4:4:4, zero 4:2:2
// - divide ratio applied only on lsb write
// - detected interface: zero analog, one digital
// - pll hsync polarity bit: one active high
// - pll coast polarity bit: one active high
package dss_pkg;
  // register offsets
  localparam logic [7:0] ADDR_PLL_DIV_MSB   = 8'h01;
  localparam logic [7:0] ADDR_PLL_DIV_LSB   = 8'h02;
  localparam logic [7:0] ADDR_PLL_CLAMP     = 8'h0f;
  localparam logic [7:0] ADDR_DETECT        = 8'h11;
  localparam logic [7:0] ADDR_SRC_SEL       = 8'h12;
  localparam logic [7:0] ADDR_SEP_THR       = 8'h13;
  localparam logic [7:0] ADDR_POL_OVR       = 8'h14;
  localparam logic [7:0] ADDR_POL_RB        = 8'h15;
  localparam logic [7:0] ADDR_SLICER        = 8'h16;
  localparam logic [7:0] ADDR_COAST_LEAD    = 8'h17;
  localparam logic [7:0] ADDR_COAST_TRAIL   = 8'h18;
  localparam logic [7:0] ADDR_FCFG_A        = 8'h19;
  localparam logic [7:0] ADDR_FCFG_B        = 8'h1a;
  localparam logic [7:0] ADDR_FCFG_C        = 8'h1b;
  localparam logic [7:0] ADDR_FORMAT        = 8'h1c;
  localparam logic [7:0] ADDR_RSVD_D        = 8'h1d;
  localparam logic [7:0] ADDR_RSVD_F        = 8'h1f;
  // reset values
  localparam logic [7:0] RST_PLL_DIV_MSB    = 8'h69;
  localparam logic [7:0] RST_PLL_DIV_LSB    = 8'hd0;
  localparam logic [7:0] RST_PLL_CLAMP      = 8'h90;
  localparam logic [7:0] RST_SRC_SEL        = 8'h01;
  localparam logic [7:0] RST_SEP_THR        = 8'h20;
  localparam logic [7:0] RST_POL_OVR        = 8'h10;
  localparam logic [7:0] RST_SLICER         = 8'hbe;
  localparam logic [7:0] RST_COAST_LEAD     = 8'h00;
  localparam logic [7:0] RST_COAST_TRAIL    = 8'h00;
  localparam logic [7:0] RST_FCFG_A         = 8'h00;
  localparam logic [7:0] RST_FCFG_B         = 8'hff;
  localparam logic [7:0] RST_FCFG_C         = 8'h00;
  localparam logic [7:0] RST_FORMAT         = 8'h07;
  localparam logic [7:0] RSVD_READ_VALUE    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;
  // field positions in source select
  localparam int BIT_IF_OVR   = 7;
  localparam int BIT_IF_SEL   = 6;
  localparam int BIT_HS_OVR   = 5;
  localparam int BIT_HS_SEL   = 4;
  localparam int BIT_VS_OVR   = 3;
  localparam int BIT_VS_SEL   = 2;
  localparam int BIT_COAST_SEL = 1;
  localparam int BIT_SLEEP_N  = 0;
  // fields elsewhere
  localparam int BIT_PLL_HS_POL    = 7;
  localparam int BIT_PLL_COAST_POL = 6;
  localparam int BIT_COAST_POL_OVR = 1;
  localparam int BIT_HS_POL_OVR    = 0;
  localparam int BIT_FMT_444       = 0;
  localparam int BIT_SLICER_ZERO   = 1;
endpackage : dss_pkg

// ### design/dss_display_sync_select_control.sv
`timescale 1ns/1ps
`default_nettype none
module dss_display_sync_select_control
(
  input  wire logic             clk_sys_i,          // register clock
  input  wire logic             rst_n_i,            // async reset, active low
  input  wire logic             wr_en_i,            // one-cycle write strobe
  input  wire logic             rd_en_i,            // one-cycle read strobe
  input  wire logic [7:0]       addr_i,             // register address
  input  wire logic [7:0]       wdata_i,            // write data
  input  wire logic             hs_detect_i,        // analog hsync present
  input  wire logic             sog_detect_i,       // sync-on-green present
  input  wire logic             vs_detect_i,        // analog vsync present
  input  wire logic             dclk_detect_i,      // digital clock present
  input  wire logic             detected_interface_i, // auto interface, 1 digital
  input  wire logic             auto_hs_src_i,      // auto hsync, 1 green
  input  wire logic             auto_vs_src_i,      // auto vsync, 1 separator
  input  wire logic             auto_hs_pol_i,      // detected hsync pol, 1 high
  input  wire logic             auto_coast_pol_i,   // detected coast pol, 1 high
  input  wire logic             vs_out_pol_i,       // vsync out pol, 0 high
  input  wire logic             hs_raw_i,           // incoming hsync level
  input  wire logic             vs_raw_i,           // raw vsync level
  input  wire logic             coast_pin_i,        // external coast level
  output logic [7:0]            rdata_o,            // read data
  output logic                  rvalid_o,           // read data valid pulse
  output logic                  digital_active_o,   // 1 digital path
  output logic                  hs_from_green_o,    // 1 hsync from green
  output logic                  vs_from_sep_o,      // 1 separated vsync
  output logic                  coast_from_vs_o,    // 1 coast from vsync
  output logic                  chip_sleep_n_o,     // 0 chip powered down
  output logic                  hs_pol_high_o,      // effective hsync polarity
  output logic                  coast_pol_high_o,   // effective coast polarity
  output logic                  format_444_o,       // 1 4:4:4, 0 4:2:2
  output logic [11:0]           pll_div_o,          // operating divide ratio
  output logic [4:0]            slicer_thr_o,       // slicer threshold
  output logic                  sep_out_o,          // sync separator output
  output logic                  coast_o             // pll coast, active high
);
  import dss_pkg::*;

  // register storage
  logic [7:0] div_msb_reg;      // staged upper divide bits
  logic [7:0] div_lsb_reg;      // lower divide bits
  logic [11:0] div_op_reg;      // ratio in use
  logic [7:0] pll_clamp_reg;    // pll and clamp control
  logic [7:0] src_sel_reg;      // input source select
  logic [7:0] sep_thr_reg;      // separator threshold
  logic [7:0] pol_ovr_reg;      // polarity override control
  logic [7:0] slicer_reg;       // slicer level control
  logic [7:0] lead_reg;         // coast lead lines
  logic [7:0] trail_reg;        // coast trail lines
  logic [7:0] fcfg_a_reg;       // factory config a
  logic [7:0] fcfg_b_reg;       // factory config b
  logic [7:0] fcfg_c_reg;       // factory config c
  logic [7:0] format_reg;       // output format control

  // pin synchronisers, three stages
  logic [2:0] hs_sync_reg;
  logic [2:0] vs_sync_reg;
  logic [2:0] cp_sync_reg;
  logic       hs_lvl_reg;       // filtered hsync level
  logic       vs_lvl_reg;       // filtered vsync level
  logic       cp_lvl_reg;       // filtered coast pin level

  // write decode
  wire wr_msb    = wr_en_i && (addr_i == ADDR_PLL_DIV_MSB);
  wire wr_lsb    = wr_en_i && (addr_i == ADDR_PLL_DIV_LSB);
  wire wr_pll    = wr_en_i && (addr_i == ADDR_PLL_CLAMP);
  wire wr_src    = wr_en_i && (addr_i == ADDR_SRC_SEL);
  wire wr_thr    = wr_en_i && (addr_i == ADDR_SEP_THR);
  wire wr_pol    = wr_en_i && (addr_i == ADDR_POL_OVR);
  wire wr_slc    = wr_en_i && (addr_i == ADDR_SLICER);
  wire wr_lead   = wr_en_i && (addr_i == ADDR_COAST_LEAD);
  wire wr_trail  = wr_en_i && (addr_i == ADDR_COAST_TRAIL);
  wire wr_fa     = wr_en_i && (addr_i == ADDR_FCFG_A);
  wire wr_fb     = wr_en_i && (addr_i == ADDR_FCFG_B);
  wire wr_fc     = wr_en_i && (addr_i == ADDR_FCFG_C);
  wire wr_fmt    = wr_en_i && (addr_i == ADDR_FORMAT);

  // detect status image
  wire [7:0] detect_word = {hs_detect_i, sog_detect_i, vs_detect_i, dclk_detect_i,
                            detected_interface_i, auto_hs_src_i, auto_vs_src_i, 1'b0};
  wire [7:0] pol_word = {auto_hs_pol_i, vs_out_pol_i, auto_coast_pol_i, 5'h00};

  // read mux
  logic [7:0] rd_mux;
  always_comb
  begin
    case (addr_i)
      ADDR_PLL_DIV_MSB: rd_mux = div_msb_reg;
      ADDR_PLL_DIV_LSB: rd_mux = div_lsb_reg;
      ADDR_PLL_CLAMP:   rd_mux = pll_clamp_reg;
      ADDR_DETECT:      rd_mux = detect_word;
      ADDR_SRC_SEL:     rd_mux = src_sel_reg;
      ADDR_SEP_THR:     rd_mux = sep_thr_reg;
      ADDR_POL_OVR:     rd_mux = pol_ovr_reg;
      ADDR_POL_RB:      rd_mux = pol_word;
      ADDR_SLICER:      rd_mux = slicer_reg;
      ADDR_COAST_LEAD:  rd_mux = lead_reg;
      ADDR_COAST_TRAIL: rd_mux = trail_reg;
      ADDR_FCFG_A:      rd_mux = fcfg_a_reg;
      ADDR_FCFG_B:      rd_mux = fcfg_b_reg;
      ADDR_FCFG_C:      rd_mux = fcfg_c_reg;
      ADDR_FORMAT:      rd_mux = format_reg;
      default:
      begin
        if (addr_i >= ADDR_RSVD_D && addr_i <= ADDR_RSVD_F)
          rd_mux = RSVD_READ_VALUE;
        else
          rd_mux = UNMAPPED_READ;
      end
    endcase
  end

  // register writes; reserved addresses have no write decode
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_msb_reg   <= RST_PLL_DIV_MSB;
      div_lsb_reg   <= RST_PLL_DIV_LSB;
      div_op_reg    <= {RST_PLL_DIV_MSB, RST_PLL_DIV_LSB[7:4]};
      pll_clamp_reg <= RST_PLL_CLAMP;
      src_sel_reg   <= RST_SRC_SEL;
      sep_thr_reg   <= RST_SEP_THR;
      pol_ovr_reg   <= RST_POL_OVR;
      slicer_reg    <= RST_SLICER;
      lead_reg      <= RST_COAST_LEAD;
      trail_reg     <= RST_COAST_TRAIL;
      fcfg_a_reg    <= RST_FCFG_A;
      fcfg_b_reg    <= RST_FCFG_B;
      fcfg_c_reg    <= RST_FCFG_C;
      format_reg    <= RST_FORMAT;
    end
    else
    begin
      if (wr_msb)   div_msb_reg   <= wdata_i;
      if (wr_lsb)   div_lsb_reg   <= {wdata_i[7:4], 4'h0};
      if (wr_lsb)   div_op_reg    <= {div_msb_reg, wdata_i[7:4]};
      if (wr_pll)   pll_clamp_reg <= wdata_i;
      if (wr_src)   src_sel_reg   <= wdata_i;
      if (wr_thr)   sep_thr_reg   <= wdata_i;
      if (wr_pol)   pol_ovr_reg   <= wdata_i;
      if (wr_slc)   slicer_reg    <= {wdata_i[7:2], 2'b00};
      if (wr_lead)  lead_reg      <= wdata_i;
      if (wr_trail) trail_reg     <= wdata_i;
      if (wr_fa)    fcfg_a_reg    <= wdata_i;
      if (wr_fb)    fcfg_b_reg    <= wdata_i;
      if (wr_fc)    fcfg_c_reg    <= wdata_i;
      if (wr_fmt)   format_reg    <= wdata_i;
    end
  end

  // source selection logic
  wire both_if  = (hs_detect_i || sog_detect_i) && dclk_detect_i;
  wire both_hs  = hs_detect_i && sog_detect_i;
  wire if_use_choice = src_sel_reg[BIT_IF_OVR] || both_if;
  wire if_next = if_use_choice ? src_sel_reg[BIT_IF_SEL] : detected_interface_i;
  wire hs_next = (src_sel_reg[BIT_HS_OVR] || both_hs) ? src_sel_reg[BIT_HS_SEL]
                                                      : auto_hs_src_i;
  wire vs_next = src_sel_reg[BIT_VS_OVR] ? src_sel_reg[BIT_VS_SEL] : auto_vs_src_i;
  wire hsp_next = pol_ovr_reg[BIT_HS_POL_OVR] ? pll_clamp_reg[BIT_PLL_HS_POL]
                                              : auto_hs_pol_i;
  wire cpp_next = pol_ovr_reg[BIT_COAST_POL_OVR] ? pll_clamp_reg[BIT_PLL_COAST_POL]
                                                 : auto_coast_pol_i;

  // pin inputs: a change counts when stages two and three agree
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hs_sync_reg <= 3'h0;
      vs_sync_reg <= 3'h0;
      cp_sync_reg <= 3'h0;
      hs_lvl_reg  <= 1'b0;
      vs_lvl_reg  <= 1'b0;
      cp_lvl_reg  <= 1'b0;
    end
    else
    begin
      hs_sync_reg <= {hs_sync_reg[1:0], hs_raw_i};
      vs_sync_reg <= {vs_sync_reg[1:0], vs_raw_i};
      cp_sync_reg <= {cp_sync_reg[1:0], coast_pin_i};
      if (hs_sync_reg[1] == hs_sync_reg[2]) hs_lvl_reg <= hs_sync_reg[2];
      if (vs_sync_reg[1] == vs_sync_reg[2]) vs_lvl_reg <= vs_sync_reg[2];
      if (cp_sync_reg[1] == cp_sync_reg[2]) cp_lvl_reg <= cp_sync_reg[2];
    end
  end

  // sync separator: output follows hsync only after a steady run past threshold,
  // so pulses shorter than the threshold are filtered out
  logic [7:0] sep_cnt_reg;
  logic       sep_reg;
  wire        sep_steady = (hs_lvl_reg == sep_reg);
  wire        sep_flip = !sep_steady && (sep_cnt_reg >= sep_thr_reg);
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sep_cnt_reg <= 8'h00;
      sep_reg     <= 1'b0;
    end
    else if (sep_steady || sep_flip)
    begin
      sep_cnt_reg <= 8'h00;
      sep_reg     <= hs_lvl_reg;
    end
    else if (sep_cnt_reg != 8'hff)
      sep_cnt_reg <= sep_cnt_reg + 8'h01;
  end

  // coast window; lead counts hsyncs before vsync using the previous frame's
  // line count, so the first frame after reset gets no lead
  logic       hs_d_reg;
  logic       vs_d_reg;
  logic [15:0] line_reg;        // lines since vsync start
  logic [15:0] frame_reg;       // lines of last frame
  logic [7:0]  trail_cnt_reg;   // trail lines remaining
  logic        coast_reg;
  wire hs_act   = hsp_next ? hs_lvl_reg : !hs_lvl_reg;
  wire vs_act   = vs_next ? sep_reg : vs_lvl_reg;
  wire hs_edge  = hs_act && !hs_d_reg;
  wire vs_edge  = vs_act && !vs_d_reg;
  wire vs_fall  = !vs_act && vs_d_reg;
  wire [15:0] lead_start = frame_reg - {8'h00, lead_reg};
  wire in_lead  = (lead_reg != 8'h00) && (frame_reg > {8'h00, lead_reg}) &&
                  (line_reg >= lead_start);
  wire in_trail = (trail_cnt_reg != 8'h00);
  wire ext_coast = cpp_next ? cp_lvl_reg : !cp_lvl_reg;
  wire coast_next = src_sel_reg[BIT_COAST_SEL] ? (vs_act || in_lead || in_trail)
                                               : ext_coast;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hs_d_reg      <= 1'b0;
      vs_d_reg      <= 1'b0;
      line_reg      <= 16'h0000;
      frame_reg     <= 16'h0000;
      trail_cnt_reg <= 8'h00;
    end
    else
    begin
      hs_d_reg <= hs_act;
      vs_d_reg <= vs_act;
      if (vs_edge)
      begin
        frame_reg <= line_reg;
        line_reg  <= 16'h0000;
      end
      else if (hs_edge && line_reg != 16'hffff)
        line_reg <= line_reg + 16'h0001;
      if (vs_fall)
        trail_cnt_reg <= trail_reg;
      else if (hs_edge && in_trail && !vs_act)
        trail_cnt_reg <= trail_cnt_reg - 8'h01;
    end
  end

  // output flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o          <= 8'h00;
      rvalid_o         <= 1'b0;
      digital_active_o <= 1'b0;
      hs_from_green_o  <= 1'b0;
      vs_from_sep_o    <= 1'b0;
      coast_from_vs_o  <= 1'b0;
      chip_sleep_n_o   <= 1'b1;
      hs_pol_high_o    <= 1'b1;
      coast_pol_high_o <= 1'b0;
      format_444_o     <= 1'b1;
      // power-up ratio shows at once, so the ratio never moves without a write
      pll_div_o        <= {RST_PLL_DIV_MSB, RST_PLL_DIV_LSB[7:4]};
      slicer_thr_o     <= 5'h00;
      sep_out_o        <= 1'b0;
      coast_reg        <= 1'b0;
    end
    else
    begin
      rvalid_o         <= rd_en_i;
      if (rd_en_i) rdata_o <= rd_mux;
      digital_active_o <= if_next;
      hs_from_green_o  <= hs_next;
      vs_from_sep_o    <= vs_next;
      coast_from_vs_o  <= src_sel_reg[BIT_COAST_SEL];
      chip_sleep_n_o   <= src_sel_reg[BIT_SLEEP_N];
      hs_pol_high_o    <= hsp_next;
      coast_pol_high_o <= cpp_next;
      format_444_o     <= format_reg[BIT_FMT_444];
      pll_div_o        <= div_op_reg;
      slicer_thr_o     <= slicer_reg[7:3];
      sep_out_o        <= sep_reg;
      coast_reg        <= coast_next;
    end
  end
  assign coast_o = coast_reg;

endmodule // dss_display_sync_select_control
`default_nettype wire

// ### test/dss_display_sync_select_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the select/control register bank
module dss_sva
(
  input  wire logic        clk_sys_i,        // register clock
  input  wire logic        rst_n_i,          // async reset, active low
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        auto_hs_pol_i,
  input  wire logic        auto_coast_pol_i,
  input  wire logic        vs_out_pol_i,
  input  wire logic [7:0]  rdata_o,
  input  wire logic        rvalid_o,
  input  wire logic        digital_active_o,
  input  wire logic        hs_from_green_o,
  input  wire logic        vs_from_sep_o,
  input  wire logic        coast_from_vs_o,
  input  wire logic        chip_sleep_n_o,
  input  wire logic        format_444_o,
  input  wire logic [11:0] pll_div_o,
  input  wire logic [4:0]  slicer_thr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // taken write to the source select register
  sequence s_wr_src;
    wr_en_i && addr_i == 8'h12;
  endsequence
  // a control output settles two edges after the write is taken
  sequence s_wr_fmt;
    wr_en_i && addr_i == 8'h1c;
  endsequence
  // three edges with no divider low-byte write: the ratio must hold
  sequence s_no_lsb;
    !(wr_en_i && addr_i == 8'h02) [*3];
  endsequence
  AST_IF_OVR: assert property (s_wr_src ##0 wdata_i[7] |-> ##2 digital_active_o == $past(wdata_i[6], 2))
    else $error("interface override not applied");
  AST_HS_OVR: assert property (s_wr_src ##0 wdata_i[5] |-> ##2 hs_from_green_o == $past(wdata_i[4], 2))
    else $error("hsync override not applied");
  AST_VS_OVR: assert property (s_wr_src ##0 wdata_i[3] |-> ##2 vs_from_sep_o == $past(wdata_i[2], 2))
    else $error("vsync override not applied");
  AST_COAST_SRC: assert property (s_wr_src |-> ##2 coast_from_vs_o == $past(wdata_i[1], 2))
    else $error("coast source not applied");
  AST_SLEEP: assert property (s_wr_src |-> ##2 chip_sleep_n_o == $past(wdata_i[0], 2))
    else $error("sleep control not applied");
  AST_FORMAT: assert property (s_wr_fmt |-> ##2 format_444_o == $past(wdata_i[0], 2))
    else $error("format select not applied");
  AST_SLICER: assert property (wr_en_i && addr_i == 8'h16 |-> ##2 slicer_thr_o == $past(wdata_i[7:3], 2))
    else $error("slicer threshold not applied");
  AST_PLL_HOLD: assert property (s_no_lsb |=> $stable(pll_div_o))
    else $error("divide ratio moved without low-byte write");
  AST_RSVD_READ: assert property (rd_en_i && addr_i inside {[8'h1d:8'h1f]} |=> rvalid_o && rdata_o == 8'h00)
    else $error("reserved read not fixed");
  AST_POL_READ: assert property (rd_en_i && addr_i == 8'h15 |=> rdata_o[7:5] == {$past(auto_hs_pol_i), $past(vs_out_pol_i), $past(auto_coast_pol_i)})
    else $error("polarity readback wrong");
endmodule // dss_sva
bind dss_display_sync_select_control dss_sva dss_sva_inst
(
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .auto_hs_pol_i(auto_hs_pol_i),
  .auto_coast_pol_i(auto_coast_pol_i), .vs_out_pol_i(vs_out_pol_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .digital_active_o(digital_active_o), .hs_from_green_o(hs_from_green_o),
  .vs_from_sep_o(vs_from_sep_o), .coast_from_vs_o(coast_from_vs_o),
  .chip_sleep_n_o(chip_sleep_n_o), .format_444_o(format_444_o), .pll_div_o(pll_div_o),
  .slicer_thr_o(slicer_thr_o)
);
`default_nettype wire

// ### test/dss_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host on the control port: one strobe per access, idle lines scrambled
module dss_host_model
(
  input  wire logic       clk_sys_i,  // register clock
  output logic            wr_en_o,    // write strobe
  output logic            rd_en_o,    // read strobe
  output logic [7:0]      addr_o,     // register address
  output logic [7:0]      wdata_o     // write data
);
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end
  // strobe stands one edge; released lines show the inverse, never stale data
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_en_o <= wr;
    rd_en_o <= ~wr;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_sys_i);
    wr_en_o <= 1'b0;
    rd_en_o <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  // bring-up writes the device needs before real use
  task automatic setup();
    acc(1'b1, 8'h1a, 8'h41);
    acc(1'b1, 8'h1b, 8'h10);
    acc(1'b1, 8'h1c, 8'h6f);
    acc(1'b1, 8'h14, 8'h10);
    acc(1'b1, 8'h13, 8'h08);
  endtask
endmodule // dss_host_model
`default_nettype wire

// ### test/display_sync_select_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module display_sync_select_control_tb;
  import dss_pkg::*;
  logic        clk_sys_i = 1'b0;   // 100 MHz register clock
  logic        rst_n_i   = 1'b0;   // async reset, active low
  logic        wr_en_i, rd_en_i;   // strobes from the host model
  logic [7:0]  addr_i, wdata_i;    // host address and data
  logic [11:0] st        = '0;     // status levels, raw vsync, coast pin
  logic        hs_raw    = 1'b0;   // hsync level into the separator
  logic [7:0]  rdata_o;
  logic        rvalid_o, dig, hsg, vss, cvs, slp, hsp, cpp, f444, sep, cst;
  logic [11:0] pll;
  logic [4:0]  slc;
  logic [15:0] exp_q[$];           // {mask, value} per pending read
  logic [15:0] e;
  logic [7:0]  d, pz;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          seed = 25994;
  // {address, mask, value} after reset; slicer low bits not compared
  logic [23:0] rst_tab [16] = '{24'h12ff01, 24'h13ff20, 24'h14ff10, 24'h16f8b8,
    24'h17ff00, 24'h18ff00, 24'h19ff00, 24'h1affff, 24'h1bff00, 24'h1cff07,
    24'h1dff00, 24'h1eff00, 24'h1fff00, 24'h01ff69, 24'h02f0d0, 24'h40ff00};
  always #5 clk_sys_i = ~clk_sys_i;
  dss_display_sync_select_control dss_display_sync_select_control_inst
  (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .hs_detect_i(st[0]), .sog_detect_i(st[1]),
    .vs_detect_i(st[2]), .dclk_detect_i(st[3]), .detected_interface_i(st[4]),
    .auto_hs_src_i(st[5]), .auto_vs_src_i(st[6]), .auto_hs_pol_i(st[7]),
    .auto_coast_pol_i(st[8]), .vs_out_pol_i(st[9]), .hs_raw_i(hs_raw),
    .vs_raw_i(st[10]), .coast_pin_i(st[11]), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .digital_active_o(dig), .hs_from_green_o(hsg), .vs_from_sep_o(vss),
    .coast_from_vs_o(cvs), .chip_sleep_n_o(slp), .hs_pol_high_o(hsp),
    .coast_pol_high_o(cpp), .format_444_o(f444), .pll_div_o(pll),
    .slicer_thr_o(slc), .sep_out_o(sep), .coast_o(cst)
  );
  dss_host_model dss_host_model_inst
  (
    .clk_sys_i(clk_sys_i), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
    .addr_o(addr_i), .wdata_o(wdata_i)
  );
  // compare and count; unknowns never match
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // note the expected read value, then issue the read
  task automatic rdq(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    exp_q.push_back({m, x});
    dss_host_model_inst.acc(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    dss_host_model_inst.acc(1'b1, a, v);
  endtask
  // outputs are looked at mid-cycle, once the launching edge has settled
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // read watcher takes the oldest note on each valid pulse; also the hang limit
  always @(negedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (rvalid_o === 1'b1)
    begin
      // a pulse with no note pending is forced to mismatch
      e = (exp_q.size() != 0) ? exp_q.pop_front() : {8'hff, ~rdata_o};
      cmp({8'h00, rdata_o & e[15:8]}, {8'h00, e[7:0] & e[15:8]});
    end
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    foreach (rst_tab[i]) rdq(rst_tab[i][23:16], rst_tab[i][7:0], rst_tab[i][15:8]);
    cmp(16'({slp, f444, pll}), 16'({2'b11, RST_PLL_DIV_MSB, RST_PLL_DIV_LSB[7:4]}));
    dss_host_model_inst.setup();
    rdq(8'h1a, 8'h41, 8'hff);
    rdq(8'h1c, 8'h6f, 8'hff);
    wr(8'h1e, 8'h5a);
    rdq(8'h1e, 8'h00, 8'hff);
    // random selections; status levels held steady per pass
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk_sys_i);
      st <= 12'($random(seed));
      d = 8'($random(seed));
      pz = 8'($random(seed));
      wr(8'h0f, pz);
      wr(8'h14, {6'b000100, d[1:0]});
      wr(8'h12, d);
      rdq(8'h12, d, 8'hff);
      idle(3);
      cmp(16'({(d[7] | ((st[0] | st[1]) & st[3])) ? d[6] : st[4], (d[5] | (st[0] & st[1])) ? d[4] : st[5], d[3] ? d[2] : st[6], d[1:0]}), 16'({dig, hsg, vss, cvs, slp}));
      cmp(16'({hsp, cpp}), 16'({d[0] ? pz[7] : st[7], d[1] ? pz[6] : st[8]}));
      // lead and trail counts are zero and the separator idles low here
      cmp(16'(cst), 16'(d[1] ? (!(d[3] ? d[2] : st[6]) & st[10]) : !(st[8] ^ st[11])));
      rdq(8'h15, {st[7], st[9], st[8], 5'h00}, 8'he0);
      rdq(8'h11, {st[0], st[1], st[2], st[3], st[4], st[5], st[6], 1'b0}, 8'hfe);
    end
    wr(8'h01, 8'h12);
    idle(3);
    cmp(16'(pll), 16'h069d);
    wr(8'h02, 8'h3c);
    idle(3);
    cmp(16'(pll), 16'h0123);
    rdq(8'h02, 8'h30, 8'hff);
    wr(8'h1c, 8'h6e);
    wr(8'h16, 8'ha8);
    idle(3);
    cmp(16'({f444, slc}), 16'({1'b0, 5'h15}));
    rdq(8'h16, 8'ha8, 8'hfa);
    wr(8'h1c, 8'h6f);
    idle(3);
    cmp(16'(f444), 16'h0001);
    // separator must not follow before the threshold of 8 has run out
    @(posedge clk_sys_i) hs_raw <= 1'b1;
    idle(12);
    cmp(16'(sep), 16'h0000);
    idle(18);
    cmp(16'(sep), 16'h0001);
    @(posedge clk_sys_i) hs_raw <= 1'b0;
    idle(12);
    cmp(16'(sep), 16'h0001);
    idle(18);
    cmp(16'(sep), 16'h0000);
    idle(4);
    end_of_test();
  end
endmodule // display_sync_select_control_tb
`default_nettype wire
